// ### rtl/ddr4_init_seq.sv
// device side power-up, reset and mode register sequencing
`timescale 1ns/10ps
`default_nettype none
`include "ddr4_init_defs.svh"
module ddr4_init_seq
#(
   parameter int unsigned XprCyc = (`TXS_CYC > `TCK_MIN_XPR) ? `TXS_CYC : `TCK_MIN_XPR,
   parameter int unsigned MrdCyc = `TMRD_CYC,
   parameter int unsigned ModCyc = `TMOD_CYC,
   parameter int unsigned DllkCyc = `TDLLK_CYC,
   parameter int unsigned ZqinitCyc = `TZQINIT_CYC
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // dram pins
   input wire logic resetPinN,
   input wire logic ckePin,
   input wire logic odtPin,
   input wire logic csPinN,
   input wire logic actPinN,
   input wire logic rasPinN,
   input wire logic casPinN,
   input wire logic wePinN,
   input wire logic [1:0] bgPin,
   input wire logic [1:0] baPin,
   input wire logic [17:0] addrPin,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   // status
   output logic odtTermOn,
   output logic initReady
);
   import ddr4_init_pkg::*;

   localparam logic [`CNT_W-1:0] XprLim = `CNT_W'(XprCyc);
   localparam logic [`CNT_W-1:0] MrdLim = `CNT_W'(MrdCyc);
   localparam logic [`CNT_W-1:0] ModLim = `CNT_W'(ModCyc);
   localparam logic [`CNT_W-1:0] ZqLim = `CNT_W'((DllkCyc > ZqinitCyc) ? DllkCyc : ZqinitCyc);

   logic [`SYNC_W-1:0] sync1_r;
   logic [`SYNC_W-1:0] sync2_r;
   pins_s pins;
   cmd_e cmd;
   mrIdx_t mrIdx;
   initState_e state_r;
   initState_e state_nxt;
   logic [`CNT_W-1:0] sinceCke_r;
   logic [`CNT_W-1:0] sinceMrs_r;
   logic [`CNT_W-1:0] sinceZq_r;
   logic [2:0] loadCnt_r;
   logic [`MR_NUM-1:0] written_r;
   logic odtPrev_r;
   logic [31:0] ctrl_r;
   logic [`ERR_W-1:0] err_r;
   logic [`ERR_W-1:0] errSet;
   logic [`ERR_W-1:0] errClr;
   logic [31:0] rdata_r;
   logic odtTerm_r;
   logic ready_r;
   logic isMrs;
   logic initPhase;
   logic rttNext;

   mr_if mr();

   // two-stage synchronizer on all pins
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
      end
      else
      begin
         sync1_r <= {resetPinN, ckePin, odtPin, csPinN, actPinN, rasPinN, casPinN,
                     wePinN, bgPin, baPin, addrPin};
         sync2_r <= sync1_r;
      end
   end

   assign pins = pins_s'(sync2_r);

   cmd_decoder u_dec
   (
      .pins (pins),
      .cmd (cmd),
      .mrIdx (mrIdx)
   );

   mode_reg_file u_mrf
   (
      .core_clk (core_clk),
      .srst (srst),
      .mr (mr)
   );

   assign isMrs = (cmd == CMD_MRS) && pins.resetN && pins.cke;
   assign initPhase = (state_r == ST_XPR) || (state_r == ST_LOAD) || (state_r == ST_ZQ);
   // nominal termination after this load, if it targets MR1
   assign rttNext = (mrIdx == 3'h1) ? |pins.addr[`MR1_RTTNOM_HI:`MR1_RTTNOM_LO]
                                    : mr.rttNomOn;

   // loads only reach the mode register file, allowed in any state past CKE
   assign mr.wrEn = isMrs && (state_r != ST_RESET) && (state_r != ST_WAIT_CKE);
   assign mr.wrIdx = mrIdx;
   assign mr.wrData = pins.addr;
   assign mr.rdIdx = mrIdx_t'(regAddr[4:2] - 3'h4);

   // expected initialization load order
   function automatic mrIdx_t seqIdx(input logic [2:0] n);
      mrIdx_t r;
      r = 3'h0;
      unique case (n)
         3'h0: r = 3'h3;
         3'h1: r = 3'h6;
         3'h2: r = 3'h5;
         3'h3: r = 3'h4;
         3'h4: r = 3'h2;
         3'h5: r = 3'h1;
         3'h6: r = 3'h0;
         3'h7: r = 3'h7;
      endcase
      return r;
   endfunction : seqIdx

   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ST_RESET: if (pins.resetN) state_nxt = ST_WAIT_CKE;
         ST_WAIT_CKE: if (pins.cke) state_nxt = ST_XPR;
         ST_XPR: if (isMrs) state_nxt = ST_LOAD;
         ST_LOAD: if (cmd == CMD_ZQCL) state_nxt = ST_ZQ;
         ST_ZQ: if (sinceZq_r >= ZqLim) state_nxt = ST_READY;
         ST_READY: state_nxt = ST_READY;
      endcase
      // any reset pulse restarts the whole power-up sequence
      if (!pins.resetN)
         state_nxt = ST_RESET;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         state_r <= ST_RESET;
      else
         state_r <= state_nxt;
   end

   // cycle counters, saturating
   always_ff @(posedge core_clk)
   begin
      if (srst || state_r == ST_WAIT_CKE || state_r == ST_RESET)
         sinceCke_r <= '0;
      else if (sinceCke_r != '1)
         sinceCke_r <= sinceCke_r + `CNT_W'(1);
   end

   always_ff @(posedge core_clk)
   begin
      if (srst || isMrs)
         sinceMrs_r <= '0;
      else if (sinceMrs_r != '1)
         sinceMrs_r <= sinceMrs_r + `CNT_W'(1);
   end

   always_ff @(posedge core_clk)
   begin
      if (srst || state_r != ST_ZQ)
         sinceZq_r <= '0;
      else if (sinceZq_r != '1)
         sinceZq_r <= sinceZq_r + `CNT_W'(1);
   end

   // load bookkeeping during initialization
   always_ff @(posedge core_clk)
   begin
      if (srst || state_r == ST_RESET)
      begin
         loadCnt_r <= 3'h0;
         written_r <= '0;
      end
      else if (mr.wrEn && mrIdx < mrIdx_t'(`MR_NUM))
      begin
         if (loadCnt_r != 3'h7)
            loadCnt_r <= loadCnt_r + 3'h1;
         written_r[mrIdx] <= 1'b1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         odtPrev_r <= 1'b0;
      else
         odtPrev_r <= pins.odt;
   end

   // protocol checks on the controller
   always_comb
   begin
      errSet = '0;
      errSet[0] = initPhase && !pins.cke && pins.resetN;
      errSet[1] = isMrs && state_r == ST_XPR && sinceCke_r < XprLim;
      errSet[2] = isMrs && initPhase && state_r != ST_XPR && sinceMrs_r < MrdLim;
      errSet[3] = (cmd == CMD_OTHER || cmd == CMD_ZQCL) && sinceMrs_r < ModLim
                  && state_r != ST_XPR && pins.cke;
      errSet[4] = ctrl_r[`CTRL_ORDER_BIT] && ((isMrs && state_r != ST_READY
                  && mrIdx != seqIdx(loadCnt_r))
                  || (cmd == CMD_ZQCL && state_r == ST_LOAD && !(&written_r)));
      errSet[5] = initPhase && sinceCke_r != '0 && pins.odt != odtPrev_r;
      // termination touched: ODT low at the load and through tMOD
      errSet[6] = (mr.rttNomOn || rttNext) && pins.odt
                  && (isMrs || (sinceMrs_r < ModLim && state_r != ST_XPR));
      errSet[6] = errSet[6] || (isMrs && initPhase && rttNext && pins.odt);
      errSet[7] = state_r == ST_LOAD && cmd == CMD_OTHER;
      errSet[7] = errSet[7] || (cmd == CMD_MRS && pins.resetN && state_r == ST_READY
                  && !pins.cke);
      if (!ctrl_r[`CTRL_CHECK_BIT])
         errSet = '0;
   end

   assign errClr = (regWr && regAddr == `REG_ERR) ? regWdata[`ERR_W-1:0] : '0;

   // set beats clear on the same cycle
   always_ff @(posedge core_clk)
   begin
      if (srst)
         err_r <= '0;
      else
         err_r <= (err_r & ~errClr) | errSet;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         ctrl_r <= `CTRL_RESET;
      else if (regWr && regAddr == `REG_CTRL)
         ctrl_r <= {30'h0, regWdata[1:0]};
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge core_clk)
   begin
      if (srst || !regRd)
         rdata_r <= '0;
      else if (regAddr == `REG_CTRL)
         rdata_r <= ctrl_r;
      else if (regAddr == `REG_STATUS)
         rdata_r <= {16'h0, 1'b0, written_r, 5'h0, 3'(state_r)};
      else if (regAddr == `REG_ERR)
         rdata_r <= {24'h0, err_r};
      else if (regAddr >= `REG_MR_BASE && regAddr <= 8'h28 && regAddr[1:0] == 2'h0)
         rdata_r <= {14'h0, mr.rdData};
      else
         rdata_r <= '0;
   end

   // termination: off in reset and until CKE first high, ignored when disabled
   always_ff @(posedge core_clk)
   begin
      if (srst || state_r == ST_RESET || state_r == ST_WAIT_CKE)
         odtTerm_r <= 1'b0;
      else
         odtTerm_r <= pins.odt && mr.rttNomOn;
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         ready_r <= 1'b0;
      else
         ready_r <= state_nxt == ST_READY;
   end

   assign regRdata = rdata_r;
   assign odtTermOn = odtTerm_r;
   assign initReady = ready_r;

   a_odt_hiz:
   assert property (@(posedge core_clk) disable iff (srst)
      (state_r == ST_RESET || state_r == ST_WAIT_CKE) |=> !odtTermOn)
      else $error("termination enabled before CKE high");

   a_odt_ignore:
   assert property (@(posedge core_clk) disable iff (srst)
      (isMrs && !mr.rttNomOn && !rttNext) |=> (!err_r[6] || $past(err_r[6])))
      else $error("odt level flagged while nominal termination off");

   a_odt_noterm:
   assert property (@(posedge core_clk) disable iff (srst)
      !mr.rttNomOn |=> !odtTermOn)
      else $error("termination on while nominal termination disabled");

   a_mrs_anytime:
   assert property (@(posedge core_clk) disable iff (srst)
      (state_r == ST_READY && isMrs && pins.resetN) |-> mr.wrEn ##1 state_r == ST_READY)
      else $error("load in ready state not accepted");

   a_ready_timing:
   assert property (@(posedge core_clk) disable iff (srst)
      (state_r == ST_ZQ && !initReady) [*2] |-> sinceZq_r <= ZqLim)
      else $error("ready late after calibration wait");
endmodule : ddr4_init_seq
`default_nettype wire

// ### rtl/ddr4_init_defs.svh
// constants for the dram initialization and mode register sequencer
`ifndef DDR4_INIT_DEFS_SVH
`define DDR4_INIT_DEFS_SVH

// mode register geometry
`define MR_W 18
`define MR_NUM 7
`define MR_IDX_W 3
`define SYNC_W 30

// power-up defaults, all fields clear
`define MR_RESET 18'h0_0000
`define MR3_GEARDOWN_BIT 3
`define MR3_PDA_BIT 4
`define MR4_MPS_BIT 1
`define MR4_CAL_HI 8
`define MR4_CAL_LO 6
`define MR5_PAR_HI 2
`define MR5_PAR_LO 0
`define MR1_RTTNOM_HI 10
`define MR1_RTTNOM_LO 8

// timing
`define CLK_PERIOD_NS 10
`define TCK_MIN_XPR 5
`define TXS_CYC 16
`define TMRD_CYC 8
`define TMOD_CYC 24
`define TDLLK_CYC 768
`define TZQINIT_CYC 1024
`define CNT_W 16

// register port map
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_ERR 8'h08
`define REG_MR_BASE 8'h10
`define CTRL_CHECK_BIT 0
`define CTRL_ORDER_BIT 1
`define CTRL_RESET 32'h0000_0001
`define ERR_W 8

`endif

// ### rtl/ddr4_init_pkg.sv
// types shared by the initialization sequencer modules
`include "ddr4_init_defs.svh"
package ddr4_init_pkg;
   typedef logic [`MR_W-1:0] mrWord_t;
   typedef logic [`MR_IDX_W-1:0] mrIdx_t;
   typedef enum {ST_RESET, ST_WAIT_CKE, ST_XPR, ST_LOAD, ST_ZQ, ST_READY} initState_e;
   typedef enum {CMD_DES, CMD_MRS, CMD_ZQCL, CMD_OTHER} cmd_e;
   typedef struct packed {
      logic resetN;
      logic cke;
      logic odt;
      logic csN;
      logic actN;
      logic rasN;
      logic casN;
      logic weN;
      logic [1:0] bg;
      logic [1:0] ba;
      logic [17:0] addr;
   } pins_s;
endpackage : ddr4_init_pkg

// ### rtl/mr_if.sv
// carrier between the sequencer and its mode register file
`timescale 1ns/10ps
`default_nettype none
interface mr_if;
   import ddr4_init_pkg::*;
   logic wrEn;
   mrIdx_t wrIdx;
   mrWord_t wrData;
   mrIdx_t rdIdx;
   mrWord_t rdData;
   logic rttNomOn;
   modport seq (output wrEn, output wrIdx, output wrData, output rdIdx,
                input rdData, input rttNomOn);
   modport regs (input wrEn, input wrIdx, input wrData, input rdIdx,
                 output rdData, output rttNomOn);
endinterface : mr_if
`default_nettype wire

// ### rtl/cmd_decoder.sv
// decodes synchronized command pins into a command and a register index
`timescale 1ns/10ps
`default_nettype none
module cmd_decoder
(
   // pins after synchronizer
   input wire ddr4_init_pkg::pins_s pins,
   // decoded
   output ddr4_init_pkg::cmd_e cmd,
   output ddr4_init_pkg::mrIdx_t mrIdx
);
   import ddr4_init_pkg::*;

   function automatic cmd_e decodeCmd(input pins_s p);
      cmd_e c;
      c = CMD_OTHER;
      if (p.csN)
         c = CMD_DES;
      else if (p.actN && !p.rasN && !p.casN && !p.weN)
         c = CMD_MRS;
      else if (p.actN && p.rasN && p.casN && !p.weN && p.addr[10])
         c = CMD_ZQCL;
      return c;
   endfunction : decodeCmd

   assign cmd = decodeCmd(pins);
   // bank group 0 is the top bit of the index
   assign mrIdx = {pins.bg[0], pins.ba[1], pins.ba[0]};
endmodule : cmd_decoder
`default_nettype wire

// ### rtl/mode_reg_file.sv
// seven mode registers, loaded whole by each accepted mode register set to index 0 to 6
`timescale 1ns/10ps
`default_nettype none
`include "ddr4_init_defs.svh"
module mode_reg_file
(
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // sequencer side
   mr_if.regs mr
);
   import ddr4_init_pkg::*;

   logic [`MR_NUM-1:0][`MR_W-1:0] regs_r;

   // every field of the selected register is replaced
   always_ff @(posedge core_clk)
   begin
      if (srst)
         regs_r <= '{default: `MR_RESET};
      else if (mr.wrEn && mr.wrIdx < mrIdx_t'(`MR_NUM))
         regs_r[mr.wrIdx] <= mr.wrData;
   end

   assign mr.rdData = (mr.rdIdx < mrIdx_t'(`MR_NUM)) ? regs_r[mr.rdIdx] : '0;
   assign mr.rttNomOn = |regs_r[1][`MR1_RTTNOM_HI:`MR1_RTTNOM_LO];

   a_mrs_index:
   assert property (@(posedge core_clk) disable iff (srst)
      (mr.wrEn && mr.wrIdx == 3'h3) |=> regs_r[3] == $past(mr.wrData))
      else $error("mode register three not loaded from its index");

   a_mrs_whole:
   assert property (@(posedge core_clk) disable iff (srst)
      (mr.wrEn && mr.wrIdx < mrIdx_t'(`MR_NUM)) |=> regs_r[$past(mr.wrIdx)] == $past(mr.wrData))
      else $error("mode register set did not replace all fields");

   a_mrs_stable:
   assert property (@(posedge core_clk) disable iff (srst)
      !mr.wrEn |=> $stable(regs_r))
      else $error("mode registers changed without a write");

   a_reset_default:
   assert property (@(posedge core_clk)
      $fell(srst) |-> (!regs_r[3][`MR3_GEARDOWN_BIT] && !regs_r[3][`MR3_PDA_BIT]
         && !regs_r[4][`MR4_MPS_BIT] && regs_r[4][`MR4_CAL_HI:`MR4_CAL_LO] == 3'h0
         && regs_r[5][`MR5_PAR_HI:`MR5_PAR_LO] == 3'h0))
      else $error("mode register defaults wrong after reset");
endmodule : mode_reg_file
`default_nettype wire

// ### sim/ddr4_ctl_model.sv
// controller-side pin driver for the initialization sequencer
`timescale 1ns/10ps
`default_nettype none
module ddr4_ctl_model
(
   // clock
   input wire logic core_clk,
   // dram pins
   output var logic resetPinN,
   output var logic ckePin,
   output var logic odtPin,
   output var logic csPinN,
   output var logic actPinN,
   output var logic rasPinN,
   output var logic casPinN,
   output var logic wePinN,
   output var logic [1:0] bgPin,
   output var logic [1:0] baPin,
   output var logic [17:0] addrPin
);
   initial
   begin
      resetPinN = 1'b0;
      ckePin = 1'b0;
      odtPin = 1'b0;
      csPinN = 1'b1;
      {actPinN, rasPinN, casPinN, wePinN} = 4'h0;
      bgPin = 2'h0;
      baPin = 2'h0;
      addrPin = 18'h0_0000;
   end

   // unselected lines show the inverse of their last value
   task automatic des();
      csPinN <= 1'b1;
      {actPinN, rasPinN, casPinN, wePinN} <= ~{actPinN, rasPinN, casPinN, wePinN};
      bgPin <= ~bgPin;
      baPin <= ~baPin;
      addrPin <= ~addrPin;
   endtask : des

   // pin reset, wait, raise cke, wait before first load
   task automatic power_up(input int holdCyc, input int waitCyc, input int xprCyc);
      @(posedge core_clk);
      ckePin <= 1'b0;
      odtPin <= 1'b0;
      resetPinN <= 1'b0;
      repeat (holdCyc) @(posedge core_clk);
      resetPinN <= 1'b1;
      repeat (waitCyc) @(posedge core_clk);
      ckePin <= 1'b1;
      repeat (xprCyc) @(posedge core_clk);
   endtask : power_up

   // kind 0 load, 1 calibration, 2 activate; then deselects
   task automatic cmd(input int kind, input logic [2:0] idx, input logic [17:0] data,
                      input int gap);
      @(posedge core_clk);
      csPinN <= 1'b0;
      actPinN <= (kind != 2);
      rasPinN <= (kind == 1);
      casPinN <= (kind == 1);
      wePinN <= 1'b0;
      bgPin <= {1'b0, idx[2]};
      baPin <= idx[1:0];
      addrPin <= (kind == 1) ? 18'h0_0400 : data;
      @(posedge core_clk);
      des();
      repeat (gap) @(posedge core_clk);
   endtask : cmd
endmodule : ddr4_ctl_model
`default_nettype wire

// ### sim/tb_ddr4_init_and_mode_register_sequencing.sv
// self-checking bench for the initialization sequencer
`timescale 1ns/10ps
`default_nettype none
`include "ddr4_init_defs.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; $display("[ERR] %0t mismatch got %h exp %h", $time, (a), (e)); end end
module tb_ddr4_init_and_mode_register_sequencing;
   import ddr4_init_pkg::*;
   localparam int Xpr = 4;
   localparam int Mrd = 4;
   localparam int Mod = 6;
   localparam int Zq = 20;
   logic core_clk;
   logic srst;
   logic resetPinN, ckePin, odtPin, csPinN, actPinN, rasPinN, casPinN, wePinN;
   logic [1:0] bgPin;
   logic [1:0] baPin;
   logic [17:0] addrPin;
   logic [7:0] regAddr;
   logic [31:0] regWdata;
   logic regWr;
   logic regRd;
   logic [31:0] regRdata;
   logic odtTermOn;
   logic initReady;
   int mismatches;
   int checks;
   logic [31:0] d;
   logic [2:0] order [7] = '{3'd3, 3'd6, 3'd5, 3'd4, 3'd2, 3'd1, 3'd0};

   ddr4_ctl_model ctl (.core_clk(core_clk), .resetPinN(resetPinN), .ckePin(ckePin),
      .odtPin(odtPin), .csPinN(csPinN), .actPinN(actPinN), .rasPinN(rasPinN),
      .casPinN(casPinN), .wePinN(wePinN), .bgPin(bgPin), .baPin(baPin), .addrPin(addrPin));

   ddr4_init_seq #(.XprCyc(Xpr), .MrdCyc(Mrd), .ModCyc(Mod), .DllkCyc(Zq), .ZqinitCyc(Zq))
   DUT (.core_clk(core_clk), .srst(srst), .resetPinN(resetPinN), .ckePin(ckePin),
      .odtPin(odtPin), .csPinN(csPinN), .actPinN(actPinN), .rasPinN(rasPinN),
      .casPinN(casPinN), .wePinN(wePinN), .bgPin(bgPin), .baPin(baPin), .addrPin(addrPin),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .odtTermOn(odtTermOn), .initReady(initReady));

   always #5 core_clk = ~core_clk;

   function automatic logic [17:0] mr_val(input int i);
      return 18'h2_A400 ^ (18'h0_1111 * 18'(i));
   endfunction : mr_val

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= v;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask : rd

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : wait_cyc

   task automatic t_reset_defaults();
      rd(`REG_CTRL);
      `CHK(d, 32'h0000_0001)
      rd(`REG_ERR);
      `CHK(d, 32'h0000_0000)
      rd(`REG_STATUS);
      `CHK(d[2:0], 3'd0)
      wr(`REG_MR_BASE + 8'h04, 32'h0003_FFFF);
      for (int i = 0; i < 7; i++)
      begin
         rd(`REG_MR_BASE + 8'(4 * i));
         `CHK(d[17:0], 18'h0_0000)
      end
      rd(8'h40);
      `CHK(d, 32'h0000_0000)
      `CHK(odtTermOn, 1'b0)
      `CHK(initReady, 1'b0)
   endtask : t_reset_defaults

   task automatic t_errors();
      ctl.power_up(12, 4, 0);
      ctl.cmd(0, 3'd3, mr_val(3), 0);
      ctl.cmd(0, 3'd6, mr_val(6), 0);
      wait_cyc(4);
      rd(`REG_ERR);
      `CHK(d[1], 1'b1)
      `CHK(d[2], 1'b1)
      @(posedge core_clk);
      ctl.ckePin <= 1'b0;
      wait_cyc(4);
      rd(`REG_ERR);
      `CHK(d[0], 1'b1)
      @(posedge core_clk);
      ctl.ckePin <= 1'b1;
      wait_cyc(4);
      wr(`REG_ERR, 32'h0000_00FF);
      rd(`REG_ERR);
      `CHK(d, 32'h0000_0000)
   endtask : t_errors

   task automatic t_full_init();
      wr(`REG_CTRL, 32'h0000_0003);
      ctl.power_up(12, 4, Xpr + 2);
      rd(`REG_STATUS);
      `CHK(d[14:8], 7'h00)
      for (int k = 0; k < 7; k++)
         ctl.cmd(0, order[k], mr_val(order[k]), (k == 6) ? Mod + 1 : Mrd + 1);
      for (int i = 0; i < 7; i++)
      begin
         rd(`REG_MR_BASE + 8'(4 * i));
         `CHK(d[17:0], mr_val(i))
      end
      rd(`REG_STATUS);
      `CHK(d[14:8], 7'h7F)
      ctl.cmd(1, 3'd0, 18'h0_0000, 8);
      #1 `CHK(initReady, 1'b0)
      wait_cyc(Zq);
      `CHK(initReady, 1'b1)
      rd(`REG_STATUS);
      `CHK(d[2:0], 3'd5)
      rd(`REG_ERR);
      `CHK(d, 32'h0000_0000)
   endtask : t_full_init

   task automatic t_tmod();
      ctl.cmd(0, 3'd2, 18'h1_5A5A, 0);
      ctl.cmd(2, 3'd0, 18'h0_0001, Mod + 2);
      rd(`REG_MR_BASE + 8'h08);
      `CHK(d[17:0], 18'h1_5A5A)
      rd(`REG_ERR);
      `CHK(d[3], 1'b1)
      wr(`REG_ERR, 32'h0000_00FF);
   endtask : t_tmod

   task automatic t_odt();
      wait_cyc(Mod);
      @(posedge core_clk);
      ctl.odtPin <= 1'b1;
      wait_cyc(5);
      `CHK(odtTermOn, 1'b1)
      rd(`REG_ERR);
      `CHK(d, 32'h0000_0000)
      @(posedge core_clk);
      ctl.resetPinN <= 1'b0;
      wait_cyc(5);
      `CHK(odtTermOn, 1'b0)
      `CHK(initReady, 1'b0)
   endtask : t_odt

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done

   initial
   begin
      core_clk = 1'b0;
      srst = 1'b1;
      regAddr = 8'h00;
      regWdata = 32'h0000_0000;
      regWr = 1'b0;
      regRd = 1'b0;
      mismatches = 0;
      checks = 0;
      repeat (12) @(posedge core_clk);
      srst <= 1'b0;
      t_reset_defaults();
      t_errors();
      t_full_init();
      t_tmod();
      t_odt();
      test_done();
   end

   initial
   begin
      #200000;
      mismatches++;
      test_done();
   end
endmodule : tb_ddr4_init_and_mode_register_sequencing
`default_nettype wire
